// file: byte_fifo.sv
// Purpose: small synchronous FIFO between the bus engine and the user side
// Assumes: single clock, asynchronous active high reset
// Notes: ready on the push side is low exactly when the buffer is full
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // filling side
  rx_push_if.sink push,
  // draining side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // honest full and empty straight from the count
  assign push.ready = (cnt_q != (AW + 1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign do_push = push.valid && push.ready;
  assign do_pop = o_valid && i_ready;

  // pointer and count update
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (do_push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (do_pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (do_push && !do_pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; contents only matter once counted in
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push.data;
    end
  end
endmodule

// file: rx_push_if.sv
// Purpose: carries received bytes from the framing engine into the buffer
// Assumes: one clock domain
// Notes: a byte moves in the cycle where valid and ready are both high
`timescale 1ns/10ps
interface rx_push_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// file: testbench.sv
// Purpose: self-checking bench for the slave framing engine
// Assumes: 10 MHz system clock, master model at 800 ns per bit
// Notes: received bytes are checked through a queue of expected values
`timescale 1ns/10ps
module testbench;
  import two_wire_pkg::*;
  logic clk, rst, gate, gc_en, ack_en, rx_ready, tx_valid, drain, na;
  logic scl_rel, sda_rel, scl_oe, sda_oe, scl_w, sda_w, rx_valid, tx_ready;
  logic busy, addressed, rd, gcall, mnack;
  logic [6:0] own;
  logic [7:0] tx_data, rx_data, r;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  logic [6:0] ta [6] = '{7'h2D, 7'h7A, 7'h00, 7'h2D, 7'h00, 7'h2C};
  int error_cnt, n_checks, seed;

  // wired-and with pull-ups
  assign scl_w = scl_rel & ~scl_oe;
  assign sda_w = sda_rel & ~sda_oe;

  two_wire_slave uut (.i_clk(clk), .i_reset(rst), .i_scl(scl_w), .i_sda(sda_w), .o_scl_o(), .o_scl_oe(scl_oe),
    .o_sda_o(), .o_sda_oe(sda_oe), .i_serial_power_gate_bit(gate), .i_own_addr(own), .i_gen_call_en(gc_en),
    .i_ack_en(ack_en), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_bus_busy(busy), .o_addressed(addressed), .o_read_mode(rd),
    .o_gen_call(gcall), .o_master_nack(mnack));
  two_wire_master_model m (.i_scl(scl_w), .i_sda(sda_w), .o_scl_rel(scl_rel), .o_sda_rel(sda_rel));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic addr(input logic [6:0] a, input logic dir, input logic exp_na);
    m.start();
    m.xfer({a, dir}, 1'b1, r, na);
    chk("addr_nack", exp_na, na);
  endtask

  task automatic wr(input logic [7:0] d, input logic exp_na);
    rxq.push_back(d);
    m.xfer(d, 1'b1, r, na);
    chk("data_nack", exp_na, na);
  endtask

  // random drain stalls, compares popped bytes, refills the send side
  always @(posedge clk) begin
    rx_ready <= drain & ($random(seed) % 2 == 0);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      chk("rx_data", rxq.pop_front(), rx_data);
    end
    if (tx_ready === 1'b1) begin
      txq.push_back(tx_data);
      tx_data <= 8'($random(seed));
    end
  end

  // hang guard, well above the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    seed = 81;
    error_cnt = 0;
    n_checks = 0;
    rst = 1'b1;
    gate = 1'b0;
    gc_en = 1'b0;
    ack_en = 1'b1;
    drain = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b1;
    tx_data = 8'h5A;
    own = 7'h2C;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("busy", 1'b0, busy);
    // write until the buffer refuses, then drain while stretched
    addr(own, 1'b0, 1'b0);
    chk("busy", 1'b1, busy);
    chk("addressed", 1'b1, addressed);
    chk("read_mode", 1'b0, rd);
    repeat (RX_FIFO_DEPTH) wr(8'($random(seed)), 1'b0);
    fork
      wr(8'($random(seed)), 1'b0);
      begin
        repeat (100) @(posedge clk);
        chk("scl_stretch", 1'b1, scl_oe);
        drain <= 1'b1;
      end
    join
    // repeated start into a read, master ends with not-acknowledge
    addr(own, 1'b1, 1'b0);
    chk("busy", 1'b1, busy);
    chk("read_mode", 1'b1, rd);
    m.xfer(8'hFF, 1'b0, r, na);
    chk("tx_byte", txq.pop_front(), r);
    m.xfer(8'hFF, 1'b1, r, na);
    chk("tx_byte", txq.pop_front(), r);
    m.stop();
    chk("master_nack", 1'b1, mnack);
    chk("busy", 1'b0, busy);
    // data refused by the receiver
    @(posedge clk) ack_en <= 1'b0;
    addr(own, 1'b0, 1'b0);
    wr(8'($random(seed)), 1'b1);
    m.stop();
    @(posedge clk) ack_en <= 1'b1;
    // address cases: mismatch, reserved, general call, mismatch with call on, call off, gated
    // general call only ever goes out with the write direction
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      own <= (i == 1) ? 7'h7A : 7'h2C;
      gc_en <= (i == 2 || i == 3);
      gate <= (i == 5);
      addr(ta[i], 1'b0, i != 2);
      if (i == 2) begin
        chk("gen_call", 1'b1, gcall);
        wr(8'($random(seed)), 1'b0);
      end
      if (i == 5) chk("busy", 1'b0, busy);
      m.stop();
    end
    @(posedge clk) gate <= 1'b0;
    repeat (40) @(posedge clk);
    chk("rx_left", 8'h00, 8'(rxq.size()));
    tally_and_finish();
  end
endmodule

// file: two_wire_master_model.sv
// Purpose: behavioural bus master for the slave under test
// Assumes: pull-ups on both lines; 800 ns bit, low 500 ns, high 300 ns
// Notes: clock stands still between frames; waits out clock stretch
`timescale 1ns/10ps
module two_wire_master_model (
  // resolved bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // open-drain drive, high means released
  output logic o_scl_rel,
  output logic o_sda_rel
);
  // both lines released at power up
  initial begin
    o_scl_rel = 1'b1;
    o_sda_rel = 1'b1;
  end
  // start from idle or repeated start from a low clock
  task automatic start();
    #250 o_sda_rel = 1'b1;
    #250 o_scl_rel = 1'b1;
    wait (i_scl);
    #300 o_sda_rel = 1'b0;
    #300 o_scl_rel = 1'b0;
  endtask
  // one bit: data set while clock low, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #250 o_sda_rel = b;
    #250 o_scl_rel = 1'b1;
    wait (i_scl);
    #150 r = i_sda;
    #150 o_scl_rel = 1'b0;
  endtask
  // eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic na);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, na);
  endtask
  // stop, with extra idle so the slave sees it before the next check
  task automatic stop();
    #250 o_sda_rel = 1'b0;
    #250 o_scl_rel = 1'b1;
    wait (i_scl);
    #300 o_sda_rel = 1'b1;
    #600;
  endtask
endmodule

// file: two_wire_pkg.sv
// Purpose: shared constants for the two-wire bus framing slave
// Assumes: system clock of 10 MHz; bus clock no faster than 400 kHz
// Notes: bit counts and address codes used by the framing engine
package two_wire_pkg;

  // bits in an address or data packet before the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // marks that the acknowledge slot has been sampled
  localparam logic [3:0] ACK_SAMPLED = 4'h9;
  // the all-zero address is the general call
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  // upper nibble of the reserved address block
  localparam logic [3:0] RESERVED_ADDR_HI = 4'hF;
  // timing: system clock and the fastest bus clock supported
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_MIN_PERIOD_NS = 2500;
  // oversampling that the engine needs to see every bus edge
  localparam int MIN_OVERSAMPLE = 16;
  localparam int SCL_MIN_PERIOD_CYC = SCL_MIN_PERIOD_NS / CLK_PERIOD_NS;
  // receive buffer shape
  localparam int RX_FIFO_WIDTH = 8;
  localparam int RX_FIFO_DEPTH = 8;

endpackage

// file: two_wire_slave.sv
// Purpose: slave-side framing engine for the two-wire serial bus
// Assumes: 10 MHz i_clk oversamples the bus clock (400 kHz at most)
// Notes: open-drain lines come as input, output and output enable
// Behaviour
// - data line changes only while the clock line is low, except start/stop
// - start and stop are data-line edges while the clock line is high
// - bus stays occupied from start until stop
// - repeated start restarts framing and keeps the bus occupied
// - address packet is seven address bits, direction bit, acknowledge
// - direction one means read from slave, zero means write
// - acknowledge own address by pulling data low in ninth clock
// - address bits arrive most significant first
// - general call with write is acknowledged when enabled, data then received
// - addresses 1111xxx are reserved and never answered
// - data packet is a byte plus acknowledge from the receiver
// - receiver acknowledges low in ninth clock, released high is not-acknowledge
// - last or unacceptable byte is answered with not-acknowledge
// - data bits go most significant first
// - interface is inoperative while the power gate bit is one
// - lines are only pulled low or released, never driven high
// - only the master makes clock pulses; slave never originates them
// - bus clock up to 400 kHz is supported
// - slave may stretch clock low; master waits for release
`timescale 1ns/10ps
module two_wire_slave
  import two_wire_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // bus lines, open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  // configuration levels
  input wire logic i_serial_power_gate_bit,
  input wire logic [6:0] i_own_addr,
  input wire logic i_gen_call_en,
  input wire logic i_ack_en,
  // received bytes
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  // bytes to send when read
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // status
  output logic o_bus_busy,
  output logic o_addressed,
  output logic o_read_mode,
  output logic o_gen_call,
  output logic o_master_nack
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_HOLD,
    ST_RX_ACK,
    ST_TX_LOAD,
    ST_TX,
    ST_TX_ACK
  } state_t;

  // does a received address byte select this slave
  function automatic logic addr_hit(input logic [7:0] pkt, input logic [6:0] own, input logic gc_en);
    logic own_ok;
    own_ok = (own[6:3] != RESERVED_ADDR_HI);
    addr_hit = ((pkt[7:1] == own) && own_ok) ||
               ((pkt[7:1] == GEN_CALL_ADDR) && gc_en && !pkt[0]);
  endfunction

  rx_push_if #(.WIDTH(RX_FIFO_WIDTH)) push ();

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] cnt_q, cnt_d;
  logic sda_oe_q, sda_oe_d;
  logic scl_oe_q, scl_oe_d;
  logic busy_q, busy_d;
  logic addressed_q, addressed_d;
  logic read_q, read_d;
  logic gc_q, gc_d;
  logic nack_q, nack_d;
  logic tx_take;

  // two flops per line; the third stage only keeps history for edges
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // bus events; 25 clocks per bus period leave ample margin for edges
  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_det = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
  assign stop_det = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

  // pushes only while a byte is complete and the buffer has room
  assign push.data = shift_q;
  assign push.valid = ((state_q == ST_RX) && scl_fall && (cnt_q == BITS_PER_BYTE)) ||
                      (state_q == ST_RX_HOLD);
  assign tx_take = (state_q == ST_TX_LOAD) && i_tx_valid && !i_serial_power_gate_bit;

  // framing state machine
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = scl_oe_q;
    busy_d = busy_q;
    addressed_d = addressed_q;
    read_d = read_q;
    gc_d = gc_q;
    nack_d = nack_q;
    if (i_serial_power_gate_bit) begin
      // gated off: release both lines and forget the bus
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
      busy_d = 1'b0;
      addressed_d = 1'b0;
      cnt_d = '0;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      busy_d = 1'b0;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
      addressed_d = 1'b0;
    end else if (start_det) begin
      // a repeated start looks the same and simply reframes
      state_d = ST_ADDR;
      busy_d = 1'b1;
      cnt_d = '0;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
      addressed_d = 1'b0;
      nack_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_d = '0; // unaddressed: wait for the next start or stop
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && (cnt_q == BITS_PER_BYTE)) begin
            if (addr_hit(shift_q, i_own_addr, i_gen_call_en)) begin
              state_d = ST_ADDR_ACK;
              sda_oe_d = 1'b1;
              addressed_d = 1'b1;
              read_d = shift_q[0];
              gc_d = (shift_q[7:1] == GEN_CALL_ADDR);
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            cnt_d = '0;
            if (read_q) begin
              state_d = ST_TX_LOAD;
              scl_oe_d = 1'b1;
            end else begin
              state_d = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && (cnt_q == BITS_PER_BYTE)) begin
            if (push.ready) begin
              state_d = ST_RX_ACK;
              sda_oe_d = i_ack_en;
            end else begin
              // buffer full: hold the clock low instead of losing a byte
              state_d = ST_RX_HOLD;
              scl_oe_d = 1'b1;
            end
          end
        end
        ST_RX_HOLD: begin
          if (push.ready) begin
            state_d = ST_RX_ACK;
            sda_oe_d = i_ack_en;
          end
        end
        ST_RX_ACK: begin
          if (scl_oe_q) scl_oe_d = 1'b0; // clock let go a cycle after the ack settles
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            cnt_d = '0;
            // after a not-acknowledge the rest of the message is ignored
            state_d = sda_oe_q ? ST_RX : ST_IDLE;
          end
        end
        ST_TX_LOAD: begin
          if (tx_take) begin
            state_d = ST_TX;
            shift_d = i_tx_data;
            sda_oe_d = !i_tx_data[7];
            cnt_d = '0;
          end
        end
        ST_TX: begin
          if (scl_oe_q) scl_oe_d = 1'b0; // first bit is on the line before the clock may rise
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              state_d = ST_TX_ACK;
              sda_oe_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_d = !shift_q[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            if (sda_s2_q) begin
              state_d = ST_IDLE;
              nack_d = 1'b1;
            end else begin
              cnt_d = ACK_SAMPLED;
            end
          end else if (scl_fall && (cnt_q == ACK_SAMPLED)) begin
            state_d = ST_TX_LOAD;
            scl_oe_d = 1'b1;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      busy_q <= 1'b0;
      addressed_q <= 1'b0;
      read_q <= 1'b0;
      gc_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      busy_q <= busy_d;
      addressed_q <= addressed_d;
      read_q <= read_d;
      gc_q <= gc_d;
      nack_q <= nack_d;
    end
  end

  // receive buffer between the bus and the user
  byte_fifo #(
    .WIDTH(RX_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .push(push),
    .o_valid(o_rx_valid),
    .o_data(o_rx_data),
    .i_ready(i_rx_ready)
  );

  // open-drain drive: output value is always low, enable pulls the line
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe = scl_oe_q;
  assign o_sda_oe = sda_oe_q;
  assign o_tx_ready = tx_take;
  assign o_bus_busy = busy_q;
  assign o_addressed = addressed_q;
  assign o_read_mode = read_q;
  assign o_gen_call = gc_q;
  assign o_master_nack = nack_q;
endmodule

// file: two_wire_slave_props.sv
// Purpose: concurrent checks on the slave framing engine ports
// Assumes: one clock domain, asynchronous active high reset
// Notes: bound onto every two_wire_slave instance
`timescale 1ns/10ps
module two_wire_slave_props
  import two_wire_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl_o,
  input wire logic o_scl_oe,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  // configuration and user side
  input wire logic i_serial_power_gate_bit,
  input wire logic [6:0] i_own_addr,
  input wire logic i_gen_call_en,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic o_tx_ready,
  // status
  input wire logic o_bus_busy,
  input wire logic o_addressed,
  input wire logic o_read_mode,
  input wire logic o_gen_call
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // open drain: the value driven is always low
  AST_NEVER_HIGH: assert property (!o_sda_o && !o_scl_o) else $error("line driven high");
  // data drive only moves while the clock is low; gate may release it any time
  AST_SDA_STABLE: assert property (i_scl && $past(i_scl) && !i_serial_power_gate_bit |-> $stable(o_sda_oe))
    else $error("data drive moved with clock high");
  AST_SDA_PULL_LOW: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("data pulled with clock high");
  AST_STRETCH_LOW: assert property ($rose(o_scl_oe) |-> !i_scl) else $error("clock pulled while high");
  AST_START_BUSY: assert property (i_scl && $past(i_scl) && $fell(i_sda) && !i_serial_power_gate_bit
    |-> ##[1:6] o_bus_busy) else $error("start not flagged busy");
  AST_STOP_IDLE: assert property (i_scl && $past(i_scl) && $rose(i_sda) |-> ##[1:6] !o_bus_busy)
    else $error("stop did not clear busy");
  AST_GATE_OFF: assert property (i_serial_power_gate_bit [*2] |-> !o_bus_busy && !o_addressed
    && !o_sda_oe && !o_scl_oe) else $error("active while gated");
  AST_ADDR_BUSY: assert property (o_addressed |-> o_bus_busy) else $error("addressed while bus free");
  AST_GC_WRITE: assert property (o_gen_call && o_addressed |-> !o_read_mode) else $error("general call read");
  AST_RESERVED: assert property (i_own_addr[6:3] == RESERVED_ADDR_HI && !i_gen_call_en |-> !o_addressed)
    else $error("reserved address answered");
  AST_TX_TAKE: assert property (o_tx_ready |-> i_tx_valid && o_read_mode && o_addressed)
    else $error("byte taken outside read");
  AST_RX_HOLD: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("head byte lost while stalled");
endmodule

bind two_wire_slave two_wire_slave_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.i_clk, .i_reset, .i_scl,
  .i_sda, .o_scl_o, .o_scl_oe, .o_sda_o, .o_sda_oe, .i_serial_power_gate_bit, .i_own_addr, .i_gen_call_en,
  .i_rx_ready, .i_tx_valid, .o_rx_valid, .o_rx_data, .o_tx_ready, .o_bus_busy, .o_addressed, .o_read_mode,
  .o_gen_call);
